// ### include/cbs_pkg.sv
// package: constants, opcodes and states of the compare, branch and skip unit
//
// Functional notes
// - compare-skip: skip next when registers equal
// - compare: destination minus source sets five flags
// - compare with carry: also subtract carry
// - compare immediate: register minus constant, flags
// - skip when register bit is clear
// - skip when register bit is set
// - skip when I/O bit is clear
// - skip when I/O bit is set
// - branch when chosen status bit set
// - branch when chosen status bit clear
// - branch equal: jump when zero set
// - branch not equal: jump when zero clear
// - branch carry set: jump when carry set
// - branch carry clear: jump when carry clear
// - same-or-higher equals carry clear branch
// - lower equals carry set branch
package cbs_pkg;
	// ==========================================================
	// widths
	localparam int CBS_DW = 8;
	localparam int CBS_PCW = 16;
	localparam int CBS_OFSW = 7;
	localparam int CBS_BSW = 3;
	localparam int CBS_RAW = 3;
	localparam int CBS_CNTW = 8;

	// ==========================================================
	// status register bit positions
	localparam int CBS_FLAG_C = 0;
	localparam int CBS_FLAG_Z = 1;
	localparam int CBS_FLAG_N = 2;
	localparam int CBS_FLAG_V = 3;
	localparam int CBS_FLAG_H = 5;
	localparam logic [CBS_DW-1:0] CBS_STATUS_RST = 8'h00;

	// ==========================================================
	// program counter steps
	localparam logic [CBS_PCW-1:0] CBS_PC_RST = 16'h0000;
	localparam logic [CBS_PCW-1:0] CBS_STEP_NEXT = 16'h0001;
	localparam logic [CBS_PCW-1:0] CBS_STEP_SKIP1 = 16'h0002;
	localparam logic [CBS_PCW-1:0] CBS_STEP_SKIP2 = 16'h0003;

	// ==========================================================
	// extra cycles after the issue cycle
	localparam logic [1:0] CBS_EXTRA_NONE = 2'h0;
	localparam logic [1:0] CBS_EXTRA_ONE = 2'h1;
	localparam logic [1:0] CBS_EXTRA_TWO = 2'h2;

	// ==========================================================
	// register port map (word index)
	localparam logic [CBS_RAW-1:0] CBS_REG_STATUS = 3'h0;
	localparam logic [CBS_RAW-1:0] CBS_REG_PC_LO = 3'h1;
	localparam logic [CBS_RAW-1:0] CBS_REG_PC_HI = 3'h2;
	localparam logic [CBS_RAW-1:0] CBS_REG_STATE = 3'h3;
	localparam logic [CBS_RAW-1:0] CBS_REG_REDIR = 3'h4;
	localparam int CBS_ST_BUSY = 0;
	localparam int CBS_ST_TAKEN = 1;
	localparam int CBS_ST_LONG = 2;

	// ==========================================================
	// operations
	typedef enum logic [3:0] {
		CBS_OP_CMP_SKIP = 4'h0,
		CBS_OP_CMP = 4'h1,
		CBS_OP_CMP_CARRY = 4'h2,
		CBS_OP_CMP_IMM = 4'h3,
		CBS_OP_SKIP_REG_CLR = 4'h4,
		CBS_OP_SKIP_REG_SET = 4'h5,
		CBS_OP_SKIP_IO_CLR = 4'h6,
		CBS_OP_SKIP_IO_SET = 4'h7,
		CBS_OP_BR_FLAG_SET = 4'h8,
		CBS_OP_BR_FLAG_CLR = 4'h9,
		CBS_OP_BR_EQ = 4'hA,
		CBS_OP_BR_NE = 4'hB,
		CBS_OP_BR_CS = 4'hC,
		CBS_OP_BR_CC = 4'hD,
		CBS_OP_BR_SH = 4'hE,
		CBS_OP_BR_LO = 4'hF
	} cbs_op_t;

	// ==========================================================
	// wait states; gray on every step but idle -> w2, an odd loop cannot be
	typedef enum logic [1:0] {
		CBS_S_IDLE = 2'b00,
		CBS_S_W1 = 2'b01,
		CBS_S_W2 = 2'b11
	} cbs_state_t;
endpackage

// ### verilog/cbs_flags.sv
// subtractor that forms the compare flags
`timescale 1ns/1ns
module cbs_flags
(
	input wire logic [cbs_pkg::CBS_DW-1:0] a_i,
	input wire logic [cbs_pkg::CBS_DW-1:0] b_i,
	input wire logic cin_i,
	output logic [cbs_pkg::CBS_DW-1:0] diff_o,
	output logic zero_o,
	output logic neg_o,
	output logic ovf_o,
	output logic carry_o,
	output logic half_o
);
	import cbs_pkg::*;

	// sign bit and the nibble borrow bit
	localparam int MSB = CBS_DW - 1;
	localparam int HALF_BIT = CBS_DW / 2 - 1;

	// ==========================================================
	// difference
	logic [CBS_DW-1:0] r;
	assign r = a_i - b_i - {{(CBS_DW-1){1'b0}}, cin_i};
	assign diff_o = r;

	// ==========================================================
	// borrows and overflow
	assign zero_o = (r == '0);
	assign neg_o = r[CBS_DW-1];
	assign carry_o = (~a_i[MSB] & b_i[MSB]) | (b_i[MSB] & r[MSB]) | (r[MSB] & ~a_i[MSB]);
	assign half_o = (~a_i[HALF_BIT] & b_i[HALF_BIT]) | (b_i[HALF_BIT] & r[HALF_BIT])
		| (r[HALF_BIT] & ~a_i[HALF_BIT]);
	assign ovf_o = (a_i[MSB] & ~b_i[MSB] & ~r[MSB]) | (~a_i[MSB] & b_i[MSB] & r[MSB]);
endmodule

// ### verilog/cbs_unit.sv
// compare, conditional skip and relative branch execution unit
`timescale 1ns/1ns
module cbs_unit
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic issue_i,
	input wire cbs_pkg::cbs_op_t op_i,
	input wire logic [cbs_pkg::CBS_DW-1:0] dst_val_i,
	input wire logic [cbs_pkg::CBS_DW-1:0] source_register_i,
	input wire logic [cbs_pkg::CBS_DW-1:0] imm_i,
	input wire logic [cbs_pkg::CBS_DW-1:0] io_val_i,
	input wire logic [cbs_pkg::CBS_BSW-1:0] bit_sel_i,
	input wire logic [cbs_pkg::CBS_OFSW-1:0] offset_i,
	input wire logic next_long_i,
	input wire logic [cbs_pkg::CBS_RAW-1:0] reg_addr_i,
	input wire logic [cbs_pkg::CBS_DW-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [cbs_pkg::CBS_DW-1:0] reg_rdata_o,
	output logic [cbs_pkg::CBS_PCW-1:0] pc_o,
	output logic [cbs_pkg::CBS_DW-1:0] status_register_o,
	output logic ready_o,
	output logic done_o,
	output logic taken_o
);
	import cbs_pkg::*;

	// ==========================================================
	// helpers
	function automatic logic [CBS_PCW-1:0] pc_add(input logic [CBS_PCW-1:0] pc,
		input logic [CBS_PCW-1:0] step);
		pc_add = pc + step;
	endfunction

	function automatic logic sel_bit(input logic [CBS_DW-1:0] v,
		input logic [CBS_BSW-1:0] idx);
		sel_bit = v[idx];
	endfunction

	// ==========================================================
	// state
	cbs_state_t state_reg;
	cbs_state_t state_next;
	logic [CBS_PCW-1:0] pc_reg;
	logic [CBS_PCW-1:0] pc_next;
	logic [CBS_DW-1:0] status_reg;
	logic [CBS_DW-1:0] status_next;
	logic [CBS_DW-1:0] rdata_reg;
	logic [CBS_DW-1:0] rdata_next;
	logic ready_reg;
	logic done_reg;
	logic taken_reg;
	logic taken_next;
	logic long_reg;
	logic long_next;
	logic [CBS_CNTW-1:0] redir_reg;
	logic [CBS_CNTW-1:0] redir_next;

	// ==========================================================
	// issue qualification
	wire accept = issue_i & ready_reg;
	wire is_cmp = (op_i == CBS_OP_CMP) | (op_i == CBS_OP_CMP_CARRY) | (op_i == CBS_OP_CMP_IMM);
	wire is_skip = (op_i == CBS_OP_CMP_SKIP) | (op_i == CBS_OP_SKIP_REG_CLR)
		| (op_i == CBS_OP_SKIP_REG_SET) | (op_i == CBS_OP_SKIP_IO_CLR)
		| (op_i == CBS_OP_SKIP_IO_SET);
	wire is_branch = ~is_cmp & ~is_skip;

	// ==========================================================
	// compare datapath
	// immediate replaces source
	wire [CBS_DW-1:0] sub_b = (op_i == CBS_OP_CMP_IMM) ? imm_i : source_register_i;
	wire sub_cin = (op_i == CBS_OP_CMP_CARRY) & status_reg[CBS_FLAG_C];
	wire [CBS_DW-1:0] sub_diff;
	wire sub_z;
	wire sub_n;
	wire sub_v;
	wire sub_c;
	wire sub_h;

	cbs_flags u_flags
	(
		.a_i(dst_val_i),
		.b_i(sub_b),
		.cin_i(sub_cin),
		.diff_o(sub_diff),
		.zero_o(sub_z),
		.neg_o(sub_n),
		.ovf_o(sub_v),
		.carry_o(sub_c),
		.half_o(sub_h)
	);

	// difference is discarded; only flags survive
	// zero chains with previous zero for multi-byte compares
	wire z_new = (op_i == CBS_OP_CMP_CARRY) ? (sub_z & status_reg[CBS_FLAG_Z]) : sub_z;
	wire [CBS_DW-1:0] status_cmp = (status_reg
		& ~((8'h01 << CBS_FLAG_C) | (8'h01 << CBS_FLAG_Z) | (8'h01 << CBS_FLAG_N)
		| (8'h01 << CBS_FLAG_V) | (8'h01 << CBS_FLAG_H)))
		| ({7'h00, sub_c} << CBS_FLAG_C) | ({7'h00, z_new} << CBS_FLAG_Z)
		| ({7'h00, sub_n} << CBS_FLAG_N) | ({7'h00, sub_v} << CBS_FLAG_V)
		| ({7'h00, sub_h} << CBS_FLAG_H);

	// ==========================================================
	// skip conditions
	wire reg_bit = sel_bit(source_register_i, bit_sel_i);
	wire io_bit = sel_bit(io_val_i, bit_sel_i);
	logic skip_cond;
	always_comb
	begin
		unique case (op_i)
			CBS_OP_CMP_SKIP: skip_cond = (dst_val_i == source_register_i);
			CBS_OP_SKIP_REG_CLR: skip_cond = ~reg_bit;
			CBS_OP_SKIP_REG_SET: skip_cond = reg_bit;
			CBS_OP_SKIP_IO_CLR: skip_cond = ~io_bit;
			CBS_OP_SKIP_IO_SET: skip_cond = io_bit;
			default: skip_cond = 1'b0;
		endcase
	end

	// ==========================================================
	// branch conditions
	wire flag_bit = sel_bit(status_reg, bit_sel_i);
	logic br_cond;
	always_comb
	begin
		unique case (op_i)
			CBS_OP_BR_FLAG_SET: br_cond = flag_bit;
			CBS_OP_BR_FLAG_CLR: br_cond = ~flag_bit;
			CBS_OP_BR_EQ: br_cond = status_reg[CBS_FLAG_Z];
			CBS_OP_BR_NE: br_cond = ~status_reg[CBS_FLAG_Z];
			CBS_OP_BR_CS, CBS_OP_BR_LO: br_cond = status_reg[CBS_FLAG_C];
			CBS_OP_BR_CC, CBS_OP_BR_SH: br_cond = ~status_reg[CBS_FLAG_C];
			default: br_cond = 1'b0;
		endcase
	end

	// ==========================================================
	// program counter target and cycle cost
	wire [CBS_PCW-1:0] ofs_ext = {{(CBS_PCW-CBS_OFSW){offset_i[CBS_OFSW-1]}}, offset_i};
	wire do_skip = is_skip & skip_cond;
	wire do_branch = is_branch & br_cond;
	// one or two words passed over
	wire [CBS_PCW-1:0] skip_step = next_long_i ? CBS_STEP_SKIP2 : CBS_STEP_SKIP1;
	wire [CBS_PCW-1:0] pc_target = do_branch ? pc_add(pc_reg, pc_add(ofs_ext, CBS_STEP_NEXT))
		: do_skip ? pc_add(pc_reg, skip_step)
		: pc_add(pc_reg, CBS_STEP_NEXT);
	wire [1:0] extra = do_branch ? CBS_EXTRA_ONE
		: do_skip ? (next_long_i ? CBS_EXTRA_TWO : CBS_EXTRA_ONE)
		: CBS_EXTRA_NONE;

	// ==========================================================
	// register port
	wire sw_status_wr = reg_wr_i & (reg_addr_i == CBS_REG_STATUS);
	wire sw_pc_lo_wr = reg_wr_i & (reg_addr_i == CBS_REG_PC_LO);
	wire sw_pc_hi_wr = reg_wr_i & (reg_addr_i == CBS_REG_PC_HI);
	wire [CBS_DW-1:0] state_view = ({7'h00, ~ready_reg} << CBS_ST_BUSY)
		| ({7'h00, taken_reg} << CBS_ST_TAKEN) | ({7'h00, long_reg} << CBS_ST_LONG);
	wire [CBS_DW-1:0] rd_mux = (reg_addr_i == CBS_REG_STATUS) ? status_reg
		: (reg_addr_i == CBS_REG_PC_LO) ? pc_reg[CBS_DW-1:0]
		: (reg_addr_i == CBS_REG_PC_HI) ? pc_reg[CBS_PCW-1:CBS_DW]
		: (reg_addr_i == CBS_REG_STATE) ? state_view
		: (reg_addr_i == CBS_REG_REDIR) ? redir_reg
		: 8'h00;
	// read data only valid in the cycle after the strobe
	assign rdata_next = reg_rd_i ? rd_mux : 8'h00;

	// ==========================================================
	// next-state logic
	always_comb
	begin
		status_next = status_reg;
		pc_next = pc_reg;
		taken_next = taken_reg;
		long_next = long_reg;
		redir_next = redir_reg;
		if (sw_status_wr)
			status_next = reg_wdata_i;
		if (sw_pc_lo_wr)
			pc_next[CBS_DW-1:0] = reg_wdata_i;
		if (sw_pc_hi_wr)
			pc_next[CBS_PCW-1:CBS_DW] = reg_wdata_i;
		// instruction wins over a software write in the same cycle
		if (accept)
		begin
			pc_next = pc_target;
			taken_next = do_skip | do_branch;
			long_next = do_skip & next_long_i;
			if (do_skip | do_branch)
				redir_next = redir_reg + 8'h01;
			if (is_cmp)
				status_next = status_cmp;
		end
	end

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			CBS_S_IDLE:
			begin
				if (accept && extra == CBS_EXTRA_TWO)
					state_next = CBS_S_W2;
				else if (accept && extra == CBS_EXTRA_ONE)
					state_next = CBS_S_W1;
			end
			CBS_S_W2: state_next = CBS_S_W1;
			CBS_S_W1: state_next = CBS_S_IDLE;
			default: state_next = CBS_S_IDLE;
		endcase
	end

	wire done_next = (accept & (extra == CBS_EXTRA_NONE)) | (state_reg == CBS_S_W1);
	wire ready_next = (state_next == CBS_S_IDLE);

	// ==========================================================
	// registers
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			state_reg <= CBS_S_IDLE;
			pc_reg <= CBS_PC_RST;
			status_reg <= CBS_STATUS_RST;
			rdata_reg <= 8'h00;
			ready_reg <= 1'b1;
			done_reg <= 1'b0;
			taken_reg <= 1'b0;
			long_reg <= 1'b0;
			redir_reg <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			pc_reg <= pc_next;
			status_reg <= status_next;
			rdata_reg <= rdata_next;
			ready_reg <= ready_next;
			done_reg <= done_next;
			taken_reg <= taken_next;
			long_reg <= long_next;
			redir_reg <= redir_next;
		end
	end

	// ==========================================================
	// outputs
	assign reg_rdata_o = rdata_reg;
	assign pc_o = pc_reg;
	assign status_register_o = status_reg;
	assign ready_o = ready_reg;
	assign done_o = done_reg;
	assign taken_o = taken_reg;
endmodule

// ### test/cbs_unit_chk.sv
// checker for the compare, branch and skip unit
`timescale 1ns/1ns
module cbs_unit_chk
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic issue_i,
	input wire cbs_pkg::cbs_op_t op_i,
	input wire logic [cbs_pkg::CBS_DW-1:0] dst_val_i,
	input wire logic [cbs_pkg::CBS_DW-1:0] source_register_i,
	input wire logic [cbs_pkg::CBS_DW-1:0] imm_i,
	input wire logic [cbs_pkg::CBS_BSW-1:0] bit_sel_i,
	input wire logic [cbs_pkg::CBS_OFSW-1:0] offset_i,
	input wire logic next_long_i,
	input wire logic reg_wr_i,
	input wire logic [cbs_pkg::CBS_PCW-1:0] pc_o,
	input wire logic [cbs_pkg::CBS_DW-1:0] status_register_o,
	input wire logic ready_o,
	input wire logic done_o,
	input wire logic taken_o
);
	import cbs_pkg::*;
	logic acc;
	logic cin;
	logic borrow;
	logic [CBS_DW-1:0] imm_diff;
	logic [CBS_DW-1:0] cpc_diff;
	logic [CBS_PCW-1:0] target;
	assign acc = issue_i && ready_o;
	assign cin = status_register_o[CBS_FLAG_C];
	assign imm_diff = dst_val_i - imm_i;
	assign cpc_diff = dst_val_i - source_register_i - {7'h00, cin};
	assign borrow = {1'b0, dst_val_i} < {1'b0, source_register_i} + 9'(cin);
	assign target = pc_o + {{9{offset_i[6]}}, offset_i} + 16'h0001;
	// ==========================================
	// assertions
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	sequence s_long_wait;
		!ready_o [*2] ##1 (ready_o && done_o);
	endsequence
	chk_skip_long:
	assert property (acc && op_i == CBS_OP_SKIP_REG_SET && source_register_i[bit_sel_i] && next_long_i
		|=> (pc_o == $past(pc_o) + 16'h0003 && taken_o) ##0 s_long_wait)
		else $error("long skip advance or timing wrong");
	chk_cmp_step:
	assert property (acc && op_i == CBS_OP_CMP |=> pc_o == $past(pc_o) + 16'h0001 && done_o && !taken_o)
		else $error("compare did not step once");
	chk_cmp_flags:
	assert property (acc && op_i == CBS_OP_CMP |=> status_register_o[CBS_FLAG_Z] ==
		($past(dst_val_i) == $past(source_register_i)) && status_register_o[CBS_FLAG_C] ==
		($past(dst_val_i) < $past(source_register_i))) else $error("compare flags wrong");
	chk_imm_flags:
	assert property (acc && op_i == CBS_OP_CMP_IMM |=> status_register_o[CBS_FLAG_N] ==
		$past(imm_diff[7]) && status_register_o[CBS_FLAG_C] == $past(dst_val_i < imm_i))
		else $error("immediate compare flags wrong");
	chk_carry_cmp:
	assert property (acc && op_i == CBS_OP_CMP_CARRY |=> status_register_o[CBS_FLAG_C] ==
		$past(borrow) && status_register_o[CBS_FLAG_Z] == $past(cpc_diff == 8'h00 && 
		status_register_o[CBS_FLAG_Z])) else $error("carry compare flags wrong");
	// a same-edge software write may change status legally
	chk_flags_kept:
	assert property (acc && !reg_wr_i && (op_i == CBS_OP_CMP_SKIP || op_i >= CBS_OP_SKIP_REG_CLR)
		|=> $stable(status_register_o)) else $error("skip or branch changed status");
	chk_eq_taken:
	assert property (acc && op_i == CBS_OP_BR_EQ && status_register_o[CBS_FLAG_Z]
		|=> pc_o == $past(target) && taken_o && !ready_o ##1 ready_o && done_o)
		else $error("equal branch not taken right");
	chk_ne_fall:
	assert property (acc && op_i == CBS_OP_BR_NE && status_register_o[CBS_FLAG_Z]
		|=> pc_o == $past(pc_o) + 16'h0001 && !taken_o && done_o)
		else $error("not-equal branch did not fall through");
endmodule
bind cbs_unit cbs_unit_chk u_chk
(
	.mclk_i(mclk_i), .rst_i(rst_i), .issue_i(issue_i), .op_i(op_i), .dst_val_i(dst_val_i),
	.source_register_i(source_register_i), .imm_i(imm_i), .bit_sel_i(bit_sel_i),
	.offset_i(offset_i), .next_long_i(next_long_i), .reg_wr_i(reg_wr_i), .pc_o(pc_o),
	.status_register_o(status_register_o), .ready_o(ready_o), .done_o(done_o), .taken_o(taken_o)
);

// ### test/tb_top.sv
// self-checking bench for the compare, branch and skip unit
`timescale 1ns/1ns
module tb_top;
	import cbs_pkg::*;
	logic mclk_i = 1'b0, rst_i = 1'b1, issue_i = 1'b0, next_long_i = 1'b0;
	logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, ready_o, done_o, taken_o;
	cbs_op_t op_i = CBS_OP_CMP;
	logic [7:0] dst_val_i = '0, source_register_i = '0, imm_i = '0, io_val_i = '0;
	logic [7:0] reg_wdata_i = '0, reg_rdata_o, status_register_o, rd_val;
	logic [2:0] bit_sel_i = '0, reg_addr_i = '0;
	logic [6:0] offset_i = '0;
	logic [15:0] pc_o;
	int errors = 0, checks = 0;
	int redirs = 0;
	always #25 mclk_i = ~mclk_i;
	cbs_unit u_dut
	(
		.mclk_i(mclk_i), .rst_i(rst_i), .issue_i(issue_i), .op_i(op_i), .dst_val_i(dst_val_i),
		.source_register_i(source_register_i), .imm_i(imm_i), .io_val_i(io_val_i),
		.bit_sel_i(bit_sel_i), .offset_i(offset_i), .next_long_i(next_long_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pc_o(pc_o),
		.status_register_o(status_register_o), .ready_o(ready_o), .done_o(done_o), .taken_o(taken_o)
	);
	// ==========================================
	// tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge mclk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1;
		rd_val = reg_rdata_o;
	endtask
	// pc starts at 0100, status preset; then one issue and its outcome
	task automatic run(input logic [3:0] op, input logic [7:0] st, exp_st,
		input logic [15:0] exp_pc, input int cyc, input logic tk);
		int n;
		wr(3'h0, st);
		wr(3'h1, 8'h00);
		wr(3'h2, 8'h01);
		@(posedge mclk_i);
		issue_i <= 1'b1;
		op_i <= cbs_op_t'(op);
		@(posedge mclk_i);
		issue_i <= 1'b0;
		#1;
		n = 1;
		// bounded so a hang ends the run as a failure
		while (done_o !== 1'b1 && n < 8)
		begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		if (n == 8)
		begin
			errors++;
			stop_test();
		end
		check(16'(n), 16'(cyc));
		check(pc_o, exp_pc);
		check(taken_o, tk);
		if (tk)
			redirs++;
		rd(3'h0);
		check(rd_val, exp_st);
	endtask
	// ==========================================
	// scenarios
	// unmapped index reads zero, state view idle after reset
	task automatic sc_idle_regs();
		rd(3'h7);
		check(rd_val, 8'h00);
		rd(3'h3);
		check(rd_val, 8'h00);
	endtask
	task automatic sc_compares();
		@(posedge mclk_i);
		dst_val_i <= 8'h10;
		source_register_i <= 8'h20;
		run(4'h1, 8'h00, 8'h05, 16'h0101, 1, 1'b0);
		@(posedge mclk_i);
		source_register_i <= 8'h10;
		run(4'h1, 8'h00, 8'h02, 16'h0101, 1, 1'b0);
		@(posedge mclk_i);
		dst_val_i <= 8'h20;
		source_register_i <= 8'h1F;
		run(4'h2, 8'h03, 8'h22, 16'h0101, 1, 1'b0);
		@(posedge mclk_i);
		dst_val_i <= 8'h80;
		imm_i <= 8'h01;
		run(4'h3, 8'h10, 8'h38, 16'h0101, 1, 1'b0);
	endtask
	task automatic sc_cmp_skip();
		@(posedge mclk_i);
		source_register_i <= 8'h80;
		next_long_i <= 1'b1;
		run(4'h0, 8'hC3, 8'hC3, 16'h0103, 3, 1'b1);
		rd(3'h3);
		check(rd_val, 8'h06);
		@(posedge mclk_i);
		next_long_i <= 1'b0;
		run(4'h0, 8'h3C, 8'h3C, 16'h0102, 2, 1'b1);
		@(posedge mclk_i);
		source_register_i <= 8'h81;
		run(4'h0, 8'h3C, 8'h3C, 16'h0101, 1, 1'b0);
	endtask
	task automatic sc_bit_skips();
		logic [3:0] oc;
		logic [2:0] b;
		logic [7:0] s;
		logic t, l;
		@(posedge mclk_i);
		source_register_i <= 8'h04;
		io_val_i <= 8'hFB;
		for (int i = 0; i < 8; i++)
		begin
			oc = 4'h4 + 4'(i % 4);
			b = 3'h2 + 3'(i / 4);
			s = (oc < 4'h6) ? 8'h04 : 8'hFB;
			t = s[b] == oc[0];
			l = oc[0] ^ b[0];
			@(posedge mclk_i);
			bit_sel_i <= b;
			next_long_i <= l;
			run(oc, 8'h5A, 8'h5A, t ? 16'h0102 + 16'(l) : 16'h0101, t ? 2 + l : 1, t);
		end
	endtask
	task automatic sc_flag_branches();
		logic [3:0] oc;
		logic [6:0] ofs;
		logic [7:0] s;
		logic t;
		@(posedge mclk_i);
		bit_sel_i <= 3'h0;
		for (int i = 0; i < 16; i++)
		begin
			oc = 4'h8 + 4'(i % 8);
			s = (i < 8) ? 8'h01 : 8'h02;
			ofs = (i < 8) ? 7'h7E : 7'h3F;
			t = ((oc == 4'hA || oc == 4'hB) ? s[1] : s[0]) ^ (oc inside {4'h9, 4'hB, 4'hD, 4'hE});
			@(posedge mclk_i);
			offset_i <= ofs;
			run(oc, s, s, 16'h0101 + (t ? {{9{ofs[6]}}, ofs} : 16'h0000), t ? 2 : 1, t);
		end
		// status bit other than carry chosen by the operand
		@(posedge mclk_i);
		bit_sel_i <= 3'h5;
		offset_i <= 7'h7E;
		run(4'h8, 8'h20, 8'h20, 16'h00FF, 2, 1'b1);
		run(4'h9, 8'h20, 8'h20, 16'h0101, 1, 1'b0);
	endtask
	// redirect count, then a reset in mid-run
	task automatic sc_mid_reset();
		rd(3'h4);
		check(rd_val, 8'(redirs));
		@(posedge mclk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		#1;
		check(pc_o, CBS_PC_RST);
		check(status_register_o, CBS_STATUS_RST);
		check({done_o, taken_o, ready_o}, 3'b001);
		rd(3'h0);
		check(rd_val, CBS_STATUS_RST);
	endtask
	initial
	begin
		repeat (5) @(posedge mclk_i);
		rst_i <= 1'b0;
		sc_idle_regs();
		sc_compares();
		sc_cmp_skip();
		sc_bit_skips();
		sc_flag_branches();
		sc_mid_reset();
		stop_test();
	end
endmodule
